// ===== rtl/display_cmd_pkg.sv
// constants and types shared by the display command decoder and its host end
// assumes one 25 MHz clock shared by both ends and a byte stream between them
package display_cmd_pkg;

	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CODE_ESC = 8'h1b;
	localparam logic [7:0] CODE_CURSOR = 8'h10;
	localparam logic [7:0] CODE_WRMODE = 8'h1a;
	localparam logic [7:0] CODE_AREA = 8'h1f;
	localparam logic [7:0] CODE_CHAR_MIN = 8'h20;
	localparam logic [7:0] SUB_WIN1 = 8'h80;
	localparam logic [7:0] SUB_WIN2 = 8'h81;
	localparam logic [7:0] SUB_PATDATA = 8'h8e;
	localparam logic [7:0] SUB_PATOPT = 8'h8f;
	localparam logic [7:0] SUB_SCROLL = 8'h90;
	localparam logic [7:0] SUB_SPEED = 8'h91;
	localparam logic [7:0] SUB_FONT = 8'h98;
	localparam logic [7:0] SUB_LINE = 8'h9a;
	localparam logic [7:0] SUB_FADE = 8'h9c;
	localparam logic [7:0] SUB_DELAY = 8'h9f;
	localparam logic [7:0] TXT_END = 8'h00;
	localparam logic [7:0] TXT_CR = 8'h0d;
	localparam logic [7:0] DLY_SCAN = 8'h00;
	localparam logic [7:0] DLY_MAX = 8'hf0;
	localparam logic [7:0] DLY_SCROLL = 8'hf8;
	localparam logic [7:0] DLY_FLASH1 = 8'hfa;
	localparam logic [7:0] DLY_FLASH2 = 8'hfb;
	localparam logic [7:0] DLY_WIPE1 = 8'hfc;
	localparam logic [7:0] DLY_WIPE2 = 8'hfd;

	// ----------------------------------------------------------------
	// counts and reset values
	// ----------------------------------------------------------------
	localparam logic [4:0] PAT_LAST = 5'd31;
	localparam logic [3:0] MAX_ROWS = 4'd8;
	localparam logic [7:0] SPEED_DEFAULT = 8'h02;
	localparam logic [7:0] SPEED_VERT_MAX = 8'h04;
	localparam logic [2:0] FONT_DEFAULT = 3'd2;
	localparam logic [3:0] GAP_DEFAULT = 4'd1;
	localparam logic [3:0] GAP_MAX = 4'd8;
	localparam logic [2:0] FADE_DEFAULT = 3'b111;
	localparam int MACRO_COUNT = 8;
	localparam logic [2:0] MACRO_BOOT = 3'd0;
	localparam int CLK_HZ = 25000000;
	localparam int DELAY_UNIT_MS = 10;
	localparam int DELAY_TICK_CYC = CLK_HZ / 1000 * DELAY_UNIT_MS;

	// ----------------------------------------------------------------
	// host register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_TXDATA = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		EV_CHAR, EV_PAT, EV_SCROLL_BYTE, EV_SCROLL_NL, EV_SCROLL_END,
		EV_LINE, EV_FADE, EV_AREA, EV_MACRO
	} evt_kind_t;

	typedef struct packed {
		evt_kind_t kind;
		logic win;
		logic [7:0] data;
		logic [7:0] aux;
		logic [7:0] x;
		logic [7:0] y;
	} evt_t;

	typedef struct packed {
		logic winSel;
		logic [1:0][3:0] patOpt;
		logic scrollPad;
		logic scrollKeep;
		logic [1:0] scrollDir;
		logic [7:0] scrollRepeat;
		logic [7:0] scrollSpeed;
		logic [2:0] fontSel;
		logic fontProp;
		logic [3:0] fontGap;
		logic [2:0] fadeLevel;
		logic [1:0] fadeSpeed;
		logic [1:0] writeMerge;
		logic horizFmt;
		logic cursorVert;
	} cfg_t;

endpackage

// ===== rtl/display_link_if.sv
// byte link between the host end and the command decoder
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface display_link_if;
	logic byteValid;
	logic [7:0] byteData;
	logic byteReady;
	logic cursorEnd;

	modport device(
		input byteValid,
		input byteData,
		output byteReady,
		output cursorEnd
	);

	modport host(
		output byteValid,
		output byteData,
		input byteReady,
		input cursorEnd
	);
endinterface

// ===== rtl/display_cmd_host.sv
// host end: AXI4-Lite slave that feeds bytes to the command decoder
// assumes software sends whole commands and watches the cursor end flag
`timescale 1ns/1ns
module display_cmd_host(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	display_link_if.host link
);
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic awHeld_q, wHeld_q, txValid_q;
	logic [7:0] awAddr_q, txData_q, wByte_q;
	logic wLane_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic doWrite;

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign link.byteValid = txValid_q;
	assign link.byteData = txData_q;
	assign doWrite = awHeld_q && wHeld_q && !bvalid_q;

	// ----------------------------------------------------------------
	// write channels
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= 8'h00;
			wByte_q <= 8'h00;
			wLane_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= display_cmd_pkg::RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready_q)
			begin
				awAddr_q <= awaddr;
				awHeld_q <= 1'b1;
				awready_q <= 1'b0;
			end
			if (wvalid && wready_q)
			begin
				wByte_q <= wdata[7:0];
				wLane_q <= wstrb[0];
				wHeld_q <= 1'b1;
				wready_q <= 1'b0;
			end
			if (doWrite)
			begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				bvalid_q <= 1'b1;
				if (awAddr_q == display_cmd_pkg::ADDR_TXDATA)
					bresp_q <= (txValid_q && wLane_q) ? display_cmd_pkg::RESP_SLVERR
						: display_cmd_pkg::RESP_OKAY;
				else if (awAddr_q == display_cmd_pkg::ADDR_STATUS)
					bresp_q <= display_cmd_pkg::RESP_OKAY;
				else
					bresp_q <= display_cmd_pkg::RESP_SLVERR;
			end
			if (bvalid_q && bready)
			begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// byte link, one byte in flight; software frames whole commands
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			txValid_q <= 1'b0;
			txData_q <= 8'h00;
		end
		else if (doWrite && awAddr_q == display_cmd_pkg::ADDR_TXDATA && wLane_q
			&& !txValid_q)
		begin
			txValid_q <= 1'b1;
			txData_q <= wByte_q;
		end
		else if (txValid_q && link.byteReady)
			txValid_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= display_cmd_pkg::RESP_OKAY;
		end
		else if (arvalid && arready_q)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= 32'h00000000;
			rresp_q <= display_cmd_pkg::RESP_OKAY;
			if (araddr == display_cmd_pkg::ADDR_STATUS)
				rdata_q[2:0] <= {link.byteReady, link.cursorEnd, txValid_q};
			else if (araddr != display_cmd_pkg::ADDR_TXDATA)
				rresp_q <= display_cmd_pkg::RESP_SLVERR;
		end
		else if (rvalid_q && rready)
		begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end
endmodule

// ===== rtl/display_cmd_device.sv
// device end: decodes the command byte stream into settings and events
// assumes drawing engines on the user side take events and report status
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module display_cmd_device #(
	parameter int TICK_CYC = display_cmd_pkg::DELAY_TICK_CYC
)(
	input wire logic ref_clk,
	input wire logic rstn,
	display_link_if.device link,
	input wire logic [3:0] glyphWidth,
	input wire logic scanDone,
	input wire logic scrollDone,
	input wire logic [1:0] flashBusy,
	input wire logic [1:0] flashInf,
	input wire logic [1:0] wipeBusy,
	output display_cmd_pkg::cfg_t cfg,
	output display_cmd_pkg::evt_t evt,
	output logic evtValid,
	output logic [7:0] cursorX,
	output logic [7:0] cursorY
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_ESC, ST_ARG, ST_PAT, ST_SCR_MODE, ST_SCR_REP, ST_SCR_TEXT,
		ST_LINE_X, ST_LINE_Y, ST_CUR_X, ST_CUR_Y, ST_WMODE, ST_AREA_CO,
		ST_AREA_DATA, ST_DELAY
	} state_t;

	state_t state_q;
	display_cmd_pkg::cfg_t cfg_q;
	display_cmd_pkg::evt_t evt_q;
	logic evtValid_q, ready_q, boot_q, endFlag_q, scrollAct_q;
	logic [7:0] sub_q, curX_q, curY_q, argX_q, dlyArg_q, periods_q, ax_q, ay_q;
	logic [4:0] patIdx_q;
	logic [3:0] rows_q;
	logic [1:0] coIdx_q;
	logic [3:0][7:0] co_q;
	logic [31:0] tick_q;
	logic take, dlyDone, areaLast;
	logic [7:0] b, rem, mask;
	logic [8:0] adv, step;

	assign cfg = cfg_q;
	assign evt = evt_q;
	assign evtValid = evtValid_q;
	assign cursorX = curX_q;
	assign cursorY = curY_q;
	assign link.byteReady = ready_q;
	assign link.cursorEnd = endFlag_q;
	assign b = link.byteData;
	assign take = link.byteValid && ready_q;

	// ----------------------------------------------------------------
	// area geometry and character advance
	// ----------------------------------------------------------------
	always_comb
	begin
		rem = cfg_q.horizFmt ? co_q[2] - ax_q : co_q[3] - ay_q;
		mask = (rem >= 8'd7) ? 8'hff : ~(8'hff >> (rem + 8'd1));
		step = cfg_q.horizFmt ? {1'b0, ax_q} + 9'd8 : {1'b0, ay_q} + 9'd8;
		areaLast = cfg_q.horizFmt ? (step > {1'b0, co_q[2]} && ay_q == co_q[3])
			: (step > {1'b0, co_q[3]} && ax_q == co_q[2]);
		adv = {1'b0, curX_q} + {5'd0, glyphWidth} + {5'd0, cfg_q.fontGap};
	end

	// ----------------------------------------------------------------
	// delay completion
	// ----------------------------------------------------------------
	always_comb
	begin
		unique case (dlyArg_q)
			display_cmd_pkg::DLY_SCAN: dlyDone = scanDone;
			display_cmd_pkg::DLY_SCROLL: dlyDone = !scrollAct_q
				|| cfg_q.scrollRepeat == 8'h00;
			display_cmd_pkg::DLY_FLASH1: dlyDone = !flashBusy[0] || flashInf[0];
			display_cmd_pkg::DLY_FLASH2: dlyDone = !flashBusy[1] || flashInf[1];
			display_cmd_pkg::DLY_WIPE1: dlyDone = !wipeBusy[0];
			display_cmd_pkg::DLY_WIPE2: dlyDone = !wipeBusy[1];
			default: dlyDone = (dlyArg_q > display_cmd_pkg::DLY_MAX)
				|| (periods_q == dlyArg_q);
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn || state_q != ST_DELAY)
		begin
			tick_q <= 32'd0;
			periods_q <= 8'h00;
		end
		else if (tick_q == 32'(TICK_CYC - 1))
		begin
			tick_q <= 32'd0;
			periods_q <= periods_q + 8'd1;
		end
		else
			tick_q <= tick_q + 32'd1;
	end

	// ----------------------------------------------------------------
	// scroll activity, a new message wins over the engine's done pulse
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			scrollAct_q <= 1'b0;
		else if (take && state_q == ST_SCR_TEXT && b == display_cmd_pkg::TXT_END)
			scrollAct_q <= 1'b1;
		else if (scrollDone)
			scrollAct_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// decoder
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			state_q <= ST_IDLE;
			ready_q <= 1'b0;
			boot_q <= 1'b1;
			endFlag_q <= 1'b0;
			evtValid_q <= 1'b0;
			evt_q <= '0;
			cfg_q <= '0;
			cfg_q.scrollSpeed <= display_cmd_pkg::SPEED_DEFAULT;
			cfg_q.fontSel <= display_cmd_pkg::FONT_DEFAULT;
			cfg_q.fontProp <= 1'b1;
			cfg_q.fontGap <= display_cmd_pkg::GAP_DEFAULT;
			cfg_q.fadeLevel <= display_cmd_pkg::FADE_DEFAULT;
			sub_q <= 8'h00;
			curX_q <= 8'h00;
			curY_q <= 8'h00;
			argX_q <= 8'h00;
			dlyArg_q <= 8'h00;
			ax_q <= 8'h00;
			ay_q <= 8'h00;
			patIdx_q <= 5'd0;
			rows_q <= 4'd1;
			coIdx_q <= 2'd0;
			co_q <= '0;
		end
		else
		begin
			evtValid_q <= 1'b0;
			evt_q.win <= cfg_q.winSel;
			evt_q.x <= curX_q;
			evt_q.y <= curY_q;
			evt_q.data <= b;
			if (boot_q)
			begin
				boot_q <= 1'b0;
				ready_q <= 1'b1;
				evtValid_q <= 1'b1;
				evt_q.kind <= display_cmd_pkg::EV_MACRO;
				evt_q.aux <= {5'd0, display_cmd_pkg::MACRO_BOOT};
			end
			else if (state_q == ST_DELAY)
			begin
				if (dlyDone)
				begin
					state_q <= ST_IDLE;
					ready_q <= 1'b1;
				end
			end
			else if (take)
			begin
				unique case (state_q)
					ST_IDLE:
					begin
						if (b == display_cmd_pkg::CODE_ESC)
							state_q <= ST_ESC;
						else if (b == display_cmd_pkg::CODE_CURSOR)
							state_q <= ST_CUR_X;
						else if (b == display_cmd_pkg::CODE_WRMODE)
							state_q <= ST_WMODE;
						else if (b == display_cmd_pkg::CODE_AREA)
						begin
							state_q <= ST_AREA_CO;
							coIdx_q <= 2'd0;
						end
						else if (b >= display_cmd_pkg::CODE_CHAR_MIN)
						begin
							evtValid_q <= 1'b1;
							evt_q.kind <= display_cmd_pkg::EV_CHAR;
							curX_q <= adv[8] ? 8'hff : adv[7:0];
							endFlag_q <= adv[8];
						end
					end
					ST_ESC:
					begin
						sub_q <= b;
						patIdx_q <= 5'd0;
						unique case (b)
							display_cmd_pkg::SUB_WIN1: state_q <= ST_IDLE;
							display_cmd_pkg::SUB_WIN2: state_q <= ST_IDLE;
							display_cmd_pkg::SUB_PATDATA: state_q <= ST_PAT;
							display_cmd_pkg::SUB_SCROLL: state_q <= ST_SCR_MODE;
							display_cmd_pkg::SUB_LINE: state_q <= ST_LINE_X;
							display_cmd_pkg::SUB_PATOPT, display_cmd_pkg::SUB_SPEED,
							display_cmd_pkg::SUB_FONT, display_cmd_pkg::SUB_FADE,
							display_cmd_pkg::SUB_DELAY: state_q <= ST_ARG;
							default: state_q <= ST_IDLE;
						endcase
						if (b == display_cmd_pkg::SUB_WIN1 || b == display_cmd_pkg::SUB_WIN2)
							cfg_q.winSel <= b[0];
					end
					ST_ARG:
					begin
						state_q <= ST_IDLE;
						unique case (sub_q)
							display_cmd_pkg::SUB_PATOPT:
								cfg_q.patOpt[cfg_q.winSel] <= b[3:0];
							display_cmd_pkg::SUB_SPEED:
								cfg_q.scrollSpeed <= (!cfg_q.scrollDir[1]
									&& b > display_cmd_pkg::SPEED_VERT_MAX)
									? display_cmd_pkg::SPEED_VERT_MAX : b;
							display_cmd_pkg::SUB_FONT:
							begin
								cfg_q.fontSel <= b[2:0];
								cfg_q.fontProp <= b[3];
								cfg_q.fontGap <= (b[6:4] == 3'd0) ? display_cmd_pkg::GAP_MAX
									: {1'b0, b[6:4]};
							end
							display_cmd_pkg::SUB_FADE:
							begin
								cfg_q.fadeLevel <= b[2:0];
								cfg_q.fadeSpeed <= b[5:4];
								evtValid_q <= 1'b1;
								evt_q.kind <= display_cmd_pkg::EV_FADE;
							end
							default:
							begin
								dlyArg_q <= b;
								ready_q <= 1'b0;
								state_q <= ST_DELAY;
							end
						endcase
					end
					ST_PAT:
					begin
						evtValid_q <= 1'b1;
						evt_q.kind <= display_cmd_pkg::EV_PAT;
						evt_q.aux <= {3'd0, patIdx_q};
						patIdx_q <= patIdx_q + 5'd1;
						if (patIdx_q == display_cmd_pkg::PAT_LAST)
							state_q <= ST_IDLE;
					end
					ST_SCR_MODE:
					begin
						cfg_q.scrollPad <= b[5];
						cfg_q.scrollKeep <= b[4];
						cfg_q.scrollDir <= b[1:0];
						state_q <= ST_SCR_REP;
					end
					ST_SCR_REP:
					begin
						cfg_q.scrollRepeat <= b;
						rows_q <= 4'd1;
						state_q <= ST_SCR_TEXT;
					end
					ST_SCR_TEXT:
					begin
						if (b == display_cmd_pkg::TXT_END)
						begin
							evtValid_q <= 1'b1;
							evt_q.kind <= display_cmd_pkg::EV_SCROLL_END;
							state_q <= ST_IDLE;
						end
						else if (b == display_cmd_pkg::TXT_CR)
						begin
							if (!(cfg_q.scrollDir[1] && rows_q == display_cmd_pkg::MAX_ROWS))
							begin
								rows_q <= rows_q + 4'd1;
								evtValid_q <= 1'b1;
								evt_q.kind <= display_cmd_pkg::EV_SCROLL_NL;
							end
						end
						else
						begin
							evtValid_q <= 1'b1;
							evt_q.kind <= display_cmd_pkg::EV_SCROLL_BYTE;
						end
					end
					ST_LINE_X:
					begin
						argX_q <= b;
						state_q <= ST_LINE_Y;
					end
					ST_LINE_Y:
					begin
						evtValid_q <= 1'b1;
						evt_q.kind <= display_cmd_pkg::EV_LINE;
						evt_q.data <= argX_q;
						evt_q.aux <= b;
						curX_q <= argX_q;
						curY_q <= b;
						state_q <= ST_IDLE;
					end
					ST_CUR_X:
					begin
						argX_q <= b;
						state_q <= ST_CUR_Y;
					end
					ST_CUR_Y:
					begin
						curX_q <= argX_q;
						curY_q <= b;
						endFlag_q <= 1'b0;
						state_q <= ST_IDLE;
					end
					ST_WMODE:
					begin
						cfg_q.writeMerge <= b[1:0];
						cfg_q.cursorVert <= b[2];
						cfg_q.horizFmt <= b[6];
						state_q <= ST_IDLE;
					end
					ST_AREA_CO:
					begin
						co_q[coIdx_q] <= b;
						coIdx_q <= coIdx_q + 2'd1;
						if (coIdx_q == 2'd3)
						begin
							ax_q <= co_q[0];
							ay_q <= co_q[1];
							state_q <= ST_AREA_DATA;
						end
					end
					ST_AREA_DATA:
					begin
						evtValid_q <= 1'b1;
						evt_q.kind <= display_cmd_pkg::EV_AREA;
						evt_q.x <= ax_q;
						evt_q.y <= ay_q;
						evt_q.aux <= mask;
						if (areaLast)
							state_q <= ST_IDLE;
						else if (cfg_q.horizFmt)
						begin
							if (step > {1'b0, co_q[2]})
							begin
								ax_q <= co_q[0];
								ay_q <= ay_q + 8'd1;
							end
							else
								ax_q <= step[7:0];
						end
						else if (step > {1'b0, co_q[3]})
						begin
							ay_q <= co_q[1];
							ax_q <= ax_q + 8'd1;
						end
						else
							ay_q <= step[7:0];
					end
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end
endmodule

// ===== test/display_window_command_decoder_assertions.sv
// link checker for the host end and command decoder pair
// assumes TICK_CYC of 10 and stimulus free of escape bytes inside data
`timescale 1ns/1ns
module display_window_command_decoder_assertions(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic byteValid,
	input wire logic [7:0] byteData,
	input wire logic byteReady,
	input wire logic cursorEnd
);
	logic [7:0] prevQ;
	logic [7:0] prev2Q;
	logic take;
	logic dlyArg;
	assign take = byteValid && byteReady;
	assign dlyArg = take && prev2Q == 8'h1b && prevQ == 8'h9f;
	// ----------------------------------------------------------------
	// last two bytes taken
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			prevQ <= 8'h00;
			prev2Q <= 8'h00;
		end
		else if (take)
		begin
			prevQ <= byteData;
			prev2Q <= prevQ;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	property p_boot_ready;
		$rose(rstn) |-> !byteReady ##1 byteReady;
	endproperty
	a_boot_ready: assert property (p_boot_ready) else $error("boot ready wrong");
	property p_boot_cursor;
		$rose(rstn) |-> !cursorEnd;
	endproperty
	a_boot_cursor: assert property (p_boot_cursor) else $error("cursor end at boot");
	property p_hold_valid;
		byteValid && !byteReady |=> byteValid;
	endproperty
	a_hold_valid: assert property (p_hold_valid) else $error("byte dropped");
	property p_hold_data;
		byteValid && !byteReady |=> $stable(byteData);
	endproperty
	a_hold_data: assert property (p_hold_data) else $error("byte changed");
	property p_one_take;
		take |=> !byteValid;
	endproperty
	a_one_take: assert property (p_one_take) else $error("byte sent twice");
	property p_delay_drop;
		dlyArg |=> !byteReady;
	endproperty
	a_delay_drop: assert property (p_delay_drop) else $error("delay not held");
	property p_delay_timed;
		dlyArg && byteData == 8'h01 |=> !byteReady [*8] ##[1:8] byteReady;
	endproperty
	a_delay_timed: assert property (p_delay_timed) else $error("delay length wrong");
	property p_delay_quick;
		dlyArg && (byteData == 8'hf1 || byteData == 8'hf8 || byteData == 8'hfa
			|| byteData == 8'hfc) |=> ##[1:4] byteReady;
	endproperty
	a_delay_quick: assert property (p_delay_quick) else $error("skip not taken");
endmodule

// ===== test/display_window_command_decoder_tb.sv
// self-checking bench for the host end and command decoder pair
// assumes TICK_CYC of 10 and a 25 MHz clock
`timescale 1ns/1ns
module display_window_command_decoder_tb;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, b;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [3:0] wstrb = 4'h0, glyphWidth = 4'h5;
	logic awready, wready, bvalid, arready, rvalid, evtValid;
	logic [1:0] bresp, rresp, resp;
	logic scanDone = 1'b1, scrollDone = 1'b0;
	logic [1:0] flashBusy = 2'h0, flashInf = 2'h0, wipeBusy = 2'h0;
	display_cmd_pkg::cfg_t cfg;
	display_cmd_pkg::evt_t evt;
	logic [7:0] cursorX, cursorY;
	logic [21:0] notes[$];
	logic [21:0] expNote;
	int errCount = 0, testsRun = 0;
	always #20 ref_clk = ~ref_clk;
	display_link_if display_link_if_inst();
	display_cmd_host display_cmd_host_inst(.ref_clk(ref_clk), .rstn(rstn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .link(display_link_if_inst));
	display_cmd_device #(.TICK_CYC(10)) display_cmd_device_inst(.ref_clk(ref_clk),
		.rstn(rstn), .link(display_link_if_inst), .glyphWidth(glyphWidth), .scanDone(scanDone),
		.scrollDone(scrollDone), .flashBusy(flashBusy), .flashInf(flashInf),
		.wipeBusy(wipeBusy), .cfg(cfg), .evt(evt), .evtValid(evtValid), .cursorX(cursorX),
		.cursorY(cursorY));
	display_window_command_decoder_assertions display_window_command_decoder_assertions_inst(
		.ref_clk(ref_clk), .rstn(rstn), .byteValid(display_link_if_inst.byteValid),
		.byteData(display_link_if_inst.byteData), .byteReady(display_link_if_inst.byteReady),
		.cursorEnd(display_link_if_inst.cursorEnd));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task reportAndStop;
		if (errCount == 0 && testsRun > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp)
		begin
			errCount++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task timeout(input string what);
		errCount++;
		$display("[ERR] %s expected done seen timeout", what);
		reportAndStop();
	endtask
	task axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic done;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		done = 1'b0;
		for (int n = 0; n < 50 && !done; n++)
		begin
			@(posedge ref_clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
			begin
				resp = bresp;
				done = 1'b1;
			end
		end
		if (!done)
			timeout("write");
	endtask
	task axiRead(input logic [7:0] a);
		logic done;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		done = 1'b0;
		for (int n = 0; n < 50 && !done; n++)
		begin
			@(posedge ref_clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
			begin
				rd = rdata;
				resp = rresp;
				done = 1'b1;
			end
		end
		if (!done)
			timeout("read");
	endtask
	task send(input logic [7:0] q[$]);
		foreach (q[i])
		begin
			resp = display_cmd_pkg::RESP_SLVERR;
			for (int n = 0; n < 100 && resp !== display_cmd_pkg::RESP_OKAY; n++)
				axiWrite(display_cmd_pkg::ADDR_TXDATA, {24'h0, q[i]}, 4'h1);
			if (resp !== display_cmd_pkg::RESP_OKAY)
				timeout("send");
		end
	endtask
	task note(input logic [3:0] k, input logic [7:0] d, input logic [7:0] a, input logic [1:0] c);
		notes.push_back({c, k, d, a});
	endtask
	task settle;
		rd = 32'h1;
		for (int n = 0; n < 100 && rd[0] !== 1'b0; n++)
			axiRead(display_cmd_pkg::ADDR_STATUS);
		if (rd[0] !== 1'b0)
			timeout("settle");
		repeat (2) @(posedge ref_clk);
	endtask
	// ----------------------------------------------------------------
	// event monitor: oldest note against each event
	// ----------------------------------------------------------------
	always @(posedge ref_clk)
	begin
		if (rstn === 1'b1 && evtValid === 1'b1)
		begin
			expNote = notes.size() > 0 ? notes.pop_front() : 22'h3fffff;
			check("event kind", expNote[19:16], evt.kind);
			if (expNote[21])
				check("event data", expNote[15:8], evt.data);
			if (expNote[20])
				check("event aux", expNote[7:0], evt.aux);
		end
	end
	initial
	begin
		void'($urandom(30));
		glyphWidth <= 4'h3 + 4'($urandom % 5);
		note(display_cmd_pkg::EV_MACRO, 8'h00, 8'h00, 2'b01);
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		flashBusy <= 2'h3;
		flashInf <= 2'h1;
		repeat (2) @(posedge ref_clk);
		axiWrite(8'h0c, 32'h0, 4'hf);
		check("bad write", display_cmd_pkg::RESP_SLVERR, resp);
		axiRead(8'h08);
		check("bad read", display_cmd_pkg::RESP_SLVERR, resp);
		axiWrite(display_cmd_pkg::ADDR_TXDATA, 32'h41, 4'h0);
		check("no strobe", display_cmd_pkg::RESP_OKAY, resp);
		check("speed default", 8'h02, cfg.scrollSpeed);
		check("font default", 5'h11, {cfg.fontProp, cfg.fontGap});
		check("fade default", 3'h7, cfg.fadeLevel);
		note(display_cmd_pkg::EV_CHAR, 8'h41, 8'h00, 2'b10);
		send('{8'h41});
		settle();
		check("cursor step", glyphWidth + 8'd1, cursorX);
		send('{8'h1b, 8'h98, 8'hb3});
		note(display_cmd_pkg::EV_CHAR, 8'hff, 8'h00, 2'b10);
		send('{8'hff});
		settle();
		check("font", 8'h63, {cfg.fontSel, cfg.fontProp, cfg.fontGap});
		check("gap step", 2 * glyphWidth + 8'd4, cursorX);
		send('{8'h1b, 8'h81, 8'h1b, 8'h8f, 8'hff, 8'h1b, 8'h8e});
		for (int i = 0; i < 32; i++)
		begin
			b = 8'h20 + 8'($urandom % 96);
			note(display_cmd_pkg::EV_PAT, b, 8'(i), 2'b11);
			send('{b});
		end
		settle();
		check("window", 1'b1, cfg.winSel);
		check("pattern opt", 8'hf0, cfg.patOpt);
		for (int d = 0; d < 4; d++)
		begin
			note(display_cmd_pkg::EV_SCROLL_END, 8'h00, 8'h00, 2'b00);
			send('{8'h1b, 8'h80, 8'h1b, 8'h90, 8'h10 | 8'(d), 8'h03, 8'h00});
			settle();
			check("scroll mode", 4'h4 | d, {cfg.scrollPad, cfg.scrollKeep, cfg.scrollDir});
			check("repeat", 8'h03, cfg.scrollRepeat);
		end
		note(display_cmd_pkg::EV_SCROLL_BYTE, 8'h41, 8'h00, 2'b10);
		note(display_cmd_pkg::EV_SCROLL_NL, 8'h00, 8'h00, 2'b00);
		note(display_cmd_pkg::EV_SCROLL_BYTE, 8'h43, 8'h00, 2'b10);
		note(display_cmd_pkg::EV_SCROLL_END, 8'h00, 8'h00, 2'b00);
		send('{8'h1b, 8'h90, 8'he6, 8'h00, 8'h41, 8'h0d, 8'h43, 8'h00, 8'h1b, 8'h91, 8'h06});
		settle();
		check("scroll mode", 4'ha, {cfg.scrollPad, cfg.scrollKeep, cfg.scrollDir});
		check("repeat", 8'h00, cfg.scrollRepeat);
		check("speed", 8'h06, cfg.scrollSpeed);
		note(display_cmd_pkg::EV_FADE, 8'h25, 8'h00, 2'b10);
		note(display_cmd_pkg::EV_LINE, 8'h30, 8'h10, 2'b11);
		send('{8'h1b, 8'h9c, 8'h25, 8'h1b, 8'h9a, 8'h30, 8'h10});
		settle();
		check("fade", 5'h15, {cfg.fadeSpeed, cfg.fadeLevel});
		check("line end", 16'h3010, {cursorX, cursorY});
		send('{8'h1a, 8'h43});
		for (int i = 0; i < 4; i++)
			note(display_cmd_pkg::EV_AREA, 8'h11 * 8'(i), i[0] ? 8'hc0 : 8'hff, 2'b11);
		send('{8'h1f, 8'h00, 8'h00, 8'h09, 8'h01, 8'h00, 8'h11, 8'h22, 8'h33});
		settle();
		check("write mode", 4'hb, {cfg.horizFmt, cfg.cursorVert, cfg.writeMerge});
		send('{8'h1b, 8'h9f, 8'h01, 8'h1b, 8'h9f, 8'hf8, 8'h1b, 8'h9f, 8'hf1, 8'h1b, 8'h9f, 8'h00});
		send('{8'h1b, 8'h9f, 8'hfa, 8'h1b, 8'h9f, 8'hfc});
		send('{8'h10, 8'hf8, 8'h00});
		for (int i = 0; i < 3; i++)
			note(display_cmd_pkg::EV_CHAR, 8'h5a, 8'h00, 2'b10);
		send('{8'h5a, 8'h5a, 8'h5a});
		settle();
		axiRead(display_cmd_pkg::ADDR_STATUS);
		check("cursor end", 1'b1, rd[1]);
		check("notes left", 32'h0, notes.size());
		reportAndStop();
	end
endmodule
